// ===== core/ilcl_pkg.sv
package ilcl_pkg;
  // Register addresses on the documented control port.
  localparam logic [6:0] ILCL_ADDR_CTRL_ONE = 7'h20;
  localparam logic [6:0] ILCL_ADDR_CTRL_TWO = 7'h21;
  localparam logic [6:0] ILCL_ADDR_CTRL_THREE = 7'h22;
  localparam logic [6:0] ILCL_ADDR_CTRL_FOUR = 7'h2a;
  localparam logic [6:0] ILCL_ADDR_AMP_VOL = 7'h2d;
  // Field positions.
  localparam int ILCL_ENABLE_BIT = 8;
  localparam int ILCL_MODE_BIT = 8;
  localparam int ILCL_ZC_BIT = 1;
  localparam int ILCL_MUTE_BIT = 6;
  localparam int ILCL_FLOOR_LSB = 0;
  localparam int ILCL_CEIL_LSB = 3;
  localparam int ILCL_LEVEL_LSB = 0;
  localparam int ILCL_HOLD_LSB = 4;
  localparam int ILCL_RISE_LSB = 4;
  localparam int ILCL_FALL_LSB = 0;
  // Reset values.
  localparam logic [8:0] ILCL_CTRL_ONE_RST = 9'h038;
  localparam logic [8:0] ILCL_CTRL_TWO_RST = 9'h00b;
  localparam logic [8:0] ILCL_CTRL_THREE_RST = 9'h032;
  localparam logic [8:0] ILCL_CTRL_FOUR_RST = 9'h000;
  localparam logic [5:0] ILCL_VOL_RST = 6'h10;
  // Codes at and above this value are held at the longest interval.
  localparam logic [3:0] ILCL_RATE_CAP = 4'ha;
  // Codes per 6dB floor or ceiling step (0.75dB per code, 0 = -12dB) and
  // the ceiling offset above the floor of the same field code.
  localparam logic [5:0] ILCL_GAIN_PER_6DB = 6'h08;
  localparam logic [5:0] ILCL_CEIL_OFFSET = 6'h07;
  // Base step intervals and the sample period, all in nanoseconds.
  localparam int ILCL_SAMPLE_NS = 22676;
  localparam int ILCL_RISE_NORM_NS = 410000;
  localparam int ILCL_FALL_NORM_NS = 104000;
  localparam int ILCL_RISE_LIM_NS = 90800;
  localparam int ILCL_FALL_LIM_NS = 22700;
  localparam int ILCL_HOLD_NS = 2670000;
  // Base intervals in sample ticks. The division truncates, and the
  // limiter fall base is pinned to one tick so it can never be zero.
  localparam int ILCL_RISE_NORM_T = ILCL_RISE_NORM_NS / ILCL_SAMPLE_NS;
  localparam int ILCL_FALL_NORM_T = ILCL_FALL_NORM_NS / ILCL_SAMPLE_NS;
  localparam int ILCL_RISE_LIM_T = ILCL_RISE_LIM_NS / ILCL_SAMPLE_NS;
  localparam int ILCL_FALL_LIM_T = 1;
  localparam int ILCL_HOLD_T = ILCL_HOLD_NS / ILCL_SAMPLE_NS;
  // Loop states.
  typedef enum logic [1:0] {
    ILCL_IDLE,
    ILCL_HOLD,
    ILCL_RUN
  } ilcl_state_type;
endpackage : ilcl_pkg

// ===== core/ilcl_step_timer.sv
`timescale 1ns/10ps
// Counts sample ticks and pulses once when the selected interval elapses.
module ilcl_step_timer
  import ilcl_pkg::*;
#(
  parameter int CNT_W = 20
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [CNT_W-1:0] base_i,
  input wire logic [3:0] code_i,
  output logic done_o
);
  logic [CNT_W-1:0] count_reg; // Sample ticks since last step.
  logic [CNT_W-1:0] term; // Terminal count for this code.
  logic [3:0] shift; // Code clamped at the cap.

  // Interval doubles per code and is held from the cap upward.
  always_comb begin
    shift = (code_i >= ILCL_RATE_CAP) ? ILCL_RATE_CAP : code_i;
    term = base_i << shift;
  end

  // Counter restarts on clear, so a new direction starts a full interval.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_reg <= '0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (clear_i) begin
        count_reg <= '0;
      end else if (tick_i) begin
        if (count_reg + 1'b1 >= term) begin
          count_reg <= '0;
          done_o <= 1'b1;
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end
endmodule : ilcl_step_timer

// ===== core/ilcl_gain_loop.sv
`timescale 1ns/10ps
// How it works
// - Control three bit 8 picks limiter mode.
// - Normal rise interval 410us doubling, capped, reset 0011.
// - Normal fall interval 104us doubling, capped, reset 0010.
// - Limiter mode uses faster rise and fall bases.
// - Intervals count sample ticks, not system clocks.
// - Disabling keeps the last loop gain.
// - Limiter lowers gain above threshold, limiter rate.
// - Limiter never raises gain above starting gain.
// - Enabling in limiter captures gain as ceiling.
// - Switch to limiter captures gain as ceiling.
// - Normal mode rises below target, falls above.
// - Loop runs only while enable bit set.
// - Normal rise after peak above target waits selected hold time first.
// - Gain kept at or above floor field.
module ilcl_gain_loop
  import ilcl_pkg::*;
#(
  parameter int CNT_W = 20 // Width of the step and hold counters.
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i, // One-cycle register write strobe.
  input wire logic [6:0] wr_addr_i, // Register address.
  input wire logic [8:0] wr_data_i, // Register write data.
  input wire logic [6:0] rd_addr_i, // Register read address.
  input wire logic sample_tick_i, // One pulse per audio sample.
  input wire logic peak_above_i, // Peak detector says above target.
  input wire logic zero_cross_i, // Signal crossed zero this cycle.
  output logic [8:0] rd_data_o, // Registered read data.
  output logic [5:0] amp_gain_o, // Gain applied to the amplifier.
  output logic amp_mute_o, // Amplifier mute.
  output logic loop_active_o // Loop is controlling the gain.
);
  logic rst_ff1_reg; // Reset synchroniser, first stage.
  logic rst_n; // Synchronised reset used everywhere else.
  logic [8:0] ctrl_one_reg; // Floor, ceiling, enable.
  logic [8:0] ctrl_two_reg; // Target level, hold time.
  logic [8:0] ctrl_three_reg; // Mode, rise and fall rates.
  logic [8:0] ctrl_four_reg; // Zero-cross enable.
  logic [6:0] vol_reg; // Mute and volume as software wrote them.
  logic [5:0] gain_reg; // Gain the amplifier sees.
  logic [5:0] start_gain_reg; // Limiter ceiling.
  logic mode_reg; // Mode seen last cycle, for edge detection.
  ilcl_state_type state_reg; // Idle, hold or run.
  logic [CNT_W-1:0] hold_cnt_reg; // Hold timer in sample ticks.
  logic pend_up_reg; // A step is waiting for a zero crossing.
  logic pend_dn_reg; // A falling step waits for a zero crossing.
  logic enable; // Loop enable bit.
  logic limiter; // Limiter mode selected.
  logic [5:0] floor_gain; // Lowest gain under loop control.
  logic [5:0] ceil_gain; // Highest gain from the ceiling field.
  logic [5:0] top_gain; // Ceiling in force for this mode.
  logic rise_done; // Rise interval elapsed.
  logic fall_done; // Fall interval elapsed.
  logic [CNT_W-1:0] rise_base; // Rise base interval in ticks.
  logic [CNT_W-1:0] fall_base; // Fall base interval in ticks.
  logic [CNT_W-1:0] hold_term; // Hold length in ticks.
  logic [3:0] hold_code; // Hold time field.
  logic step_up; // Raise gain by one code this cycle.
  logic step_dn; // Lower gain by one code this cycle.
  logic dir_change; // Peak rose above target while running.

  // Reset is asserted at once and released through two flip-flops.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_ff1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_ff1_reg <= 1'b1;
      rst_n <= rst_ff1_reg;
    end
  end

  // Field decode.
  assign enable = ctrl_one_reg[ILCL_ENABLE_BIT];
  assign limiter = ctrl_three_reg[ILCL_MODE_BIT];
  assign hold_code = ctrl_two_reg[ILCL_HOLD_LSB +: 4];

  // Floor and ceiling: 6dB apart per code, ceiling 5.25dB above the floor
  // of the same code, in 0.75dB gain codes.
  assign floor_gain = 6'(ctrl_one_reg[ILCL_FLOOR_LSB +: 3]
      * ILCL_GAIN_PER_6DB);
  assign ceil_gain = 6'(ctrl_one_reg[ILCL_CEIL_LSB +: 3]
      * ILCL_GAIN_PER_6DB) + ILCL_CEIL_OFFSET;
  // In limiter mode the captured start gain is the top as well.
  assign top_gain = (limiter && start_gain_reg < ceil_gain)
      ? start_gain_reg : ceil_gain;

  // Bases chosen by mode; all counted in sample ticks.
  assign rise_base = limiter ? CNT_W'(ILCL_RISE_LIM_T)
      : CNT_W'(ILCL_RISE_NORM_T);
  assign fall_base = limiter ? CNT_W'(ILCL_FALL_LIM_T)
      : CNT_W'(ILCL_FALL_NORM_T);
  // Hold: 0 at code 0, else base doubling, held from the cap.
  assign hold_term = (hold_code == 4'h0) ? '0
      : CNT_W'(ILCL_HOLD_T) << ((hold_code >= ILCL_RATE_CAP)
      ? 4'(ILCL_RATE_CAP - 4'h1) : 4'(hold_code - 4'h1));

  // A change of direction restarts both timers.
  assign dir_change = (state_reg == ILCL_RUN) && peak_above_i;

  ilcl_step_timer #(.CNT_W(CNT_W)) u_rise (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .clear_i(state_reg != ILCL_RUN || peak_above_i),
    .tick_i(sample_tick_i),
    .base_i(rise_base),
    .code_i(ctrl_three_reg[ILCL_RISE_LSB +: 4]),
    .done_o(rise_done)
  );

  ilcl_step_timer #(.CNT_W(CNT_W)) u_fall (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .clear_i(state_reg == ILCL_IDLE || !peak_above_i),
    .tick_i(sample_tick_i),
    .base_i(fall_base),
    .code_i(ctrl_three_reg[ILCL_FALL_LSB +: 4]),
    .done_o(fall_done)
  );

  // Register writes from the control port; reset values on reset.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_one_reg <= ILCL_CTRL_ONE_RST;
      ctrl_two_reg <= ILCL_CTRL_TWO_RST;
      ctrl_three_reg <= ILCL_CTRL_THREE_RST;
      ctrl_four_reg <= ILCL_CTRL_FOUR_RST;
      vol_reg <= {1'b1, ILCL_VOL_RST};
    end else if (wr_en_i) begin
      case (wr_addr_i)
        ILCL_ADDR_CTRL_ONE: ctrl_one_reg <= wr_data_i;
        ILCL_ADDR_CTRL_TWO: ctrl_two_reg <= wr_data_i;
        ILCL_ADDR_CTRL_THREE: ctrl_three_reg <= wr_data_i;
        ILCL_ADDR_CTRL_FOUR: ctrl_four_reg <= wr_data_i;
        ILCL_ADDR_AMP_VOL: vol_reg <= wr_data_i[6:0];
        default: ; // Other addresses belong to other blocks.
      endcase
    end
  end

  // Loop state: idle while disabled, hold after the peak was above target in normal mode, run otherwise.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ILCL_IDLE;
      hold_cnt_reg <= '0;
    end else begin
      case (state_reg)
        ILCL_IDLE: begin
          if (enable) begin
            state_reg <= ILCL_RUN;
          end
        end
        ILCL_HOLD: begin
          // Hold only applies in normal mode; limiter skips it.
          // Falling steps go on here while the rise timer stays cleared,
          // so no rise can start before the hold has run out.
          if (!enable) begin
            state_reg <= ILCL_IDLE;
            hold_cnt_reg <= '0;
          end else if (limiter) begin
            state_reg <= ILCL_RUN;
            hold_cnt_reg <= '0;
          end else if (peak_above_i) begin
            hold_cnt_reg <= '0; // Still above target: hold restarts.
          end else if (hold_cnt_reg >= hold_term) begin
            state_reg <= ILCL_RUN;
            hold_cnt_reg <= '0;
          end else if (sample_tick_i) begin
            hold_cnt_reg <= hold_cnt_reg + 1'b1;
          end
        end
        ILCL_RUN: begin
          if (!enable) begin
            state_reg <= ILCL_IDLE;
          end else if (dir_change && !limiter) begin
            state_reg <= ILCL_HOLD; // Re-arm the hold for next drop.
          end
        end
        default: state_reg <= ILCL_IDLE;
      endcase
    end
  end

  // Step requests wait for a zero crossing when that option is on.
  // A step left over from the other direction is dropped, so a late
  // timer pulse can never move the gain against the peak.
  assign step_up = (pend_up_reg || rise_done) && !peak_above_i
      && (!ctrl_four_reg[ILCL_ZC_BIT] || zero_cross_i);
  assign step_dn = (pend_dn_reg || fall_done) && peak_above_i
      && (!ctrl_four_reg[ILCL_ZC_BIT] || zero_cross_i);

  // Pending flags hold a step that arrived before the crossing.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_up_reg <= 1'b0;
      pend_dn_reg <= 1'b0;
    end else if (state_reg == ILCL_IDLE) begin
      pend_up_reg <= 1'b0;
      pend_dn_reg <= 1'b0;
    end else begin
      pend_up_reg <= (pend_up_reg || rise_done) && !step_up
          && !peak_above_i;
      pend_dn_reg <= (pend_dn_reg || fall_done) && !step_dn
          && peak_above_i;
    end
  end

  // Gain register. Written volume applies only while the loop is off,
  // and disabling leaves the last loop gain in place.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      gain_reg <= ILCL_VOL_RST;
    end else if (wr_en_i && wr_addr_i == ILCL_ADDR_AMP_VOL && !enable) begin
      gain_reg <= wr_data_i[5:0];
    end else if (state_reg != ILCL_IDLE && enable) begin
      if (gain_reg < floor_gain) begin
        gain_reg <= floor_gain;
      end else if (gain_reg > top_gain) begin
        gain_reg <= top_gain;
      end else if (step_dn && gain_reg > floor_gain) begin
        gain_reg <= gain_reg - 6'h01;
      end else if (step_up && gain_reg < top_gain) begin
        gain_reg <= gain_reg + 6'h01;
      end
    end
  end

  // Capture the start gain on enable in limiter mode or on switchover.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      start_gain_reg <= '0;
      mode_reg <= 1'b0;
    end else begin
      mode_reg <= limiter;
      if (state_reg == ILCL_IDLE && enable && limiter) begin
        start_gain_reg <= gain_reg;
      end else if (state_reg != ILCL_IDLE && limiter && !mode_reg) begin
        start_gain_reg <= gain_reg;
      end
    end
  end

  // Outputs and read-back; volume reads show the live loop gain.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_o <= '0;
      amp_gain_o <= ILCL_VOL_RST;
      amp_mute_o <= 1'b1;
      loop_active_o <= 1'b0;
    end else begin
      amp_gain_o <= gain_reg;
      // Mute must be cleared by software before enabling.
      amp_mute_o <= vol_reg[ILCL_MUTE_BIT];
      loop_active_o <= (state_reg != ILCL_IDLE);
      case (rd_addr_i)
        ILCL_ADDR_CTRL_ONE: rd_data_o <= ctrl_one_reg;
        ILCL_ADDR_CTRL_TWO: rd_data_o <= ctrl_two_reg;
        ILCL_ADDR_CTRL_THREE: rd_data_o <= ctrl_three_reg;
        ILCL_ADDR_CTRL_FOUR: rd_data_o <= ctrl_four_reg;
        ILCL_ADDR_AMP_VOL: rd_data_o <= {2'b00, vol_reg[6], gain_reg};
        default: rd_data_o <= '0;
      endcase
    end
  end
endmodule : ilcl_gain_loop

// ===== bench/ilcl_gain_loop_assertions.sv
`timescale 1ns/10ps
// Port checker for the gain loop; shadows track the programmed fields.
module ilcl_gain_loop_assertions
  import ilcl_pkg::*;
#(
  parameter int CNT_W = 20 // Kept in step with the design.
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic [6:0] wr_addr_i,
  input wire logic [8:0] wr_data_i,
  input wire logic [6:0] rd_addr_i,
  input wire logic sample_tick_i,
  input wire logic peak_above_i,
  input wire logic zero_cross_i,
  input wire logic [8:0] rd_data_o,
  input wire logic [5:0] amp_gain_o,
  input wire logic amp_mute_o,
  input wire logic loop_active_o
);
  logic [8:0] one_reg; // Shadow of control one.
  logic [8:0] three_reg; // Shadow of control three.
  logic [6:0] vol_reg; // Shadow of mute and volume.
  logic [2:0] quiet_reg; // Cycles since a write; also masks reset sync.
  // Shadows follow the writes so checks know the programmed fields.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      one_reg <= ILCL_CTRL_ONE_RST;
      three_reg <= ILCL_CTRL_THREE_RST;
      vol_reg <= {1'b1, ILCL_VOL_RST};
    end else if (wr_en_i) begin
      if (wr_addr_i == ILCL_ADDR_CTRL_ONE) one_reg <= wr_data_i;
      if (wr_addr_i == ILCL_ADDR_CTRL_THREE) three_reg <= wr_data_i;
      if (wr_addr_i == ILCL_ADDR_AMP_VOL) vol_reg <= wr_data_i[6:0];
    end
  end
  // Clamping may follow a write, so range checks wait for quiet time.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) quiet_reg <= 3'h0;
    else if (wr_en_i) quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  gain_step_a: assert property (
    loop_active_o && $past(loop_active_o) && quiet_reg > 3'h3 |->
    6'(amp_gain_o - $past(amp_gain_o)) inside {6'h00, 6'h01, 6'h3f})
    else $error("gain moved more than one step");
  idle_hold_a: assert property (
    (!loop_active_o [*4] ##0 quiet_reg > 3'h3) |-> $stable(amp_gain_o))
    else $error("gain moved while loop off");
  vol_apply_a: assert property (
    wr_en_i && wr_addr_i == ILCL_ADDR_AMP_VOL && !one_reg[8] |->
    ##[1:2] amp_gain_o == vol_reg[5:0]) else $error("volume not applied");
  mute_store_a: assert property (
    wr_en_i && wr_addr_i == ILCL_ADDR_AMP_VOL |->
    ##[1:2] amp_mute_o == vol_reg[6]) else $error("mute not stored");
  loop_on_a: assert property (
    wr_en_i && wr_addr_i == ILCL_ADDR_CTRL_ONE && wr_data_i[8] |->
    ##3 loop_active_o) else $error("loop did not start");
  loop_off_a: assert property (
    wr_en_i && wr_addr_i == ILCL_ADDR_CTRL_ONE && !wr_data_i[8] |->
    ##3 !loop_active_o) else $error("loop did not stop");
  gain_floor_a: assert property (
    loop_active_o && quiet_reg == 3'h7 |->
    amp_gain_o >= {one_reg[2:0], 3'b000}) else $error("gain under floor");
  mode_read_a: assert property (
    rd_addr_i == ILCL_ADDR_CTRL_THREE && !wr_en_i && quiet_reg > 3'h3
    |=> rd_data_o == three_reg) else $error("control three misread");
  cover property (loop_active_o && three_reg[8]);
  cover property (wr_en_i && wr_addr_i == ILCL_ADDR_AMP_VOL);
  cover property (loop_active_o && amp_gain_o == {one_reg[2:0], 3'b000});
endmodule : ilcl_gain_loop_assertions

bind ilcl_gain_loop ilcl_gain_loop_assertions #(.CNT_W(CNT_W)) chk_i (
  .clk_i(clk_i), .arst_n_i(arst_n_i), .wr_en_i(wr_en_i),
  .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i),
  .sample_tick_i(sample_tick_i), .peak_above_i(peak_above_i),
  .zero_cross_i(zero_cross_i), .rd_data_o(rd_data_o),
  .amp_gain_o(amp_gain_o), .amp_mute_o(amp_mute_o),
  .loop_active_o(loop_active_o));

// ===== bench/ilcl_gain_loop_test.sv
`timescale 1ns/10ps
// Self-checking bench: registers, step timing, modes and hand-over.
module ilcl_gain_loop_test
  import ilcl_pkg::*;
;
  logic clk_i = 0, arst_n_i = 0, wr_en_i = 0, sample_tick_i = 0;
  logic peak_above_i = 0, zero_cross_i = 0, amp_mute_o, loop_active_o;
  logic [6:0] wr_addr_i = 7'h00, rd_addr_i = 7'h00;
  logic [8:0] wr_data_i = 9'h000, rd_data_o, d;
  logic [5:0] amp_gain_o, g0, g1;
  logic [3:0] rc, fc;
  int miscompares = 0, n_tests = 0;
  ilcl_gain_loop #(.CNT_W(20)) DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
    .rd_addr_i(rd_addr_i), .sample_tick_i(sample_tick_i),
    .peak_above_i(peak_above_i), .zero_cross_i(zero_cross_i),
    .rd_data_o(rd_data_o), .amp_gain_o(amp_gain_o),
    .amp_mute_o(amp_mute_o), .loop_active_o(loop_active_o));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // Sample ticks every other clock keep long intervals short to run.
  always @(posedge clk_i) sample_tick_i <= #1 ~sample_tick_i;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_c
  task automatic wr(input logic [6:0] a, input logic [8:0] v);
    @(posedge clk_i);
    #1 wr_en_i = 1;
    wr_addr_i = a;
    wr_data_i = v;
    wait_c(1);
    wr_en_i = 0;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [8:0] e);
    @(posedge clk_i);
    #1 rd_addr_i = a;
    wait_c(1);
    check(16'(rd_data_o), 16'(e));
  endtask : rd
  // Ticks between two gain steps; the first step only aligns us.
  task automatic meas(input int exp);
    logic [5:0] g;
    int n;
    int k;
    for (int s = 0; s < 2; s++) begin
      g = amp_gain_o;
      n = 0;
      k = 0;
      while (amp_gain_o === g && k < 20000) begin
        @(posedge clk_i);
        if (sample_tick_i) n++;
        #1 k++;
      end
    end
    check(16'(n), 16'(exp));
  endtask : meas
  // Expected step interval in ticks; codes past the cap hold the top.
  function automatic int step(input int base, input logic [3:0] code);
    return base << ((code > ILCL_RATE_CAP) ? ILCL_RATE_CAP : code);
  endfunction : step
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // Watchdog sized well past the expected run of some 11000 cycles.
  initial begin
    #450000;
    miscompares++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h2d84));
    wait_c(2);
    arst_n_i = 1;
    wait_c(4);
    rd(ILCL_ADDR_CTRL_ONE, ILCL_CTRL_ONE_RST);
    rd(ILCL_ADDR_CTRL_TWO, ILCL_CTRL_TWO_RST);
    rd(ILCL_ADDR_CTRL_THREE, ILCL_CTRL_THREE_RST);
    rd(ILCL_ADDR_CTRL_FOUR, ILCL_CTRL_FOUR_RST);
    rd(ILCL_ADDR_AMP_VOL, {3'b001, ILCL_VOL_RST});
    rd(7'h23, 9'h000);
    for (int i = 0; i < 4; i++) begin
      d = 9'($urandom);
      wr(ILCL_ADDR_CTRL_THREE, d);
      rd(ILCL_ADDR_CTRL_THREE, d);
    end
    wr(ILCL_ADDR_CTRL_FOUR, 9'h002);
    rd(ILCL_ADDR_CTRL_FOUR, 9'h002);
    $display("register test done");
    rc = 4'($urandom % 3);
    fc = 4'($urandom % 3);
    wr(ILCL_ADDR_CTRL_FOUR, 9'h000);
    wr(ILCL_ADDR_AMP_VOL, 9'h020);
    wr(ILCL_ADDR_CTRL_THREE, {1'b0, rc, fc});
    wr(ILCL_ADDR_CTRL_ONE, 9'h138);
    check(16'(amp_mute_o), 16'h0000);
    meas(step(ILCL_RISE_NORM_T, rc));
    peak_above_i = 1;
    meas(step(ILCL_FALL_NORM_T, fc));
    wr(ILCL_ADDR_CTRL_ONE, 9'h13a);
    wait_c(3000);
    check(16'(amp_gain_o), 16'h0010);
    wr(ILCL_ADDR_CTRL_TWO, 9'h01b);
    peak_above_i = 0;
    wait_c(2 * ILCL_HOLD_T - 10);
    check(16'(amp_gain_o), 16'h0010);
    wait_c(2 * step(ILCL_RISE_NORM_T, rc) + 30);
    check(16'(amp_gain_o), 16'h0011);
    $display("normal mode test done");
    wr(ILCL_ADDR_CTRL_ONE, 9'h03a);
    wait_c(200);
    check(16'(amp_gain_o), 16'h0011);
    peak_above_i = 1;
    g0 = 6'h18 + 6'($urandom % 16);
    wr(ILCL_ADDR_AMP_VOL, {3'b000, g0});
    wait_c(3);
    check(16'(amp_gain_o), 16'(g0));
    wr(ILCL_ADDR_CTRL_THREE, {1'b1, rc, 4'hf});
    wr(ILCL_ADDR_CTRL_ONE, 9'h13a);
    meas(step(ILCL_FALL_LIM_T, 4'hf));
    peak_above_i = 0;
    meas(step(ILCL_RISE_LIM_T, rc));
    wait_c(500);
    check(16'(amp_gain_o), 16'(g0));
    $display("limiter test done");
    wr(ILCL_ADDR_CTRL_FOUR, 9'h002);
    wr(ILCL_ADDR_CTRL_THREE, {1'b0, rc, fc});
    wait_c(1000);
    check(16'(amp_gain_o), 16'(g0));
    zero_cross_i = 1;
    wait_c(400);
    zero_cross_i = 0;
    wait_c(20);
    g1 = amp_gain_o;
    check(16'(g1 > g0), 16'h0001);
    wr(ILCL_ADDR_CTRL_THREE, {1'b1, rc, fc});
    zero_cross_i = 1;
    wait_c(600);
    check(16'(amp_gain_o), 16'(g1));
    peak_above_i = 1;
    wait_c(300);
    check(16'(amp_gain_o < g1), 16'h0001);
    wr(ILCL_ADDR_CTRL_ONE, 9'h03a);
    wait_c(4);
    g1 = amp_gain_o;
    wait_c(300);
    check(16'(amp_gain_o), 16'(g1));
    check(16'(loop_active_o), 16'h0000);
    $display("switch and disable test done");
    end_of_test();
  end
endmodule : ilcl_gain_loop_test
